// >>> logic/spd_pkg.sv
// Shared constants for the single-pin debug port register set
package spd_pkg;
  // Register offsets in the port register space
  localparam logic [3:0] SPD_OFS_REVISION   = 4'h0;
  localparam logic [3:0] SPD_OFS_ERRSIG     = 4'h1;
  localparam logic [3:0] SPD_OFS_CTRL_A     = 4'h2;
  localparam logic [3:0] SPD_OFS_CTRL_B     = 4'h3;
  localparam logic [3:0] SPD_OFS_KEY_STATUS = 4'h7;
  localparam logic [3:0] SPD_OFS_RESET_REQ  = 4'h8;
  localparam logic [3:0] SPD_OFS_CLK_SEL    = 4'h9;
  localparam logic [3:0] SPD_OFS_SYS_CTRL_A = 4'ha;
  localparam logic [3:0] SPD_OFS_SYS_STATUS = 4'hb;
  localparam logic [3:0] SPD_OFS_CRC_STATUS = 4'hc;
  // Field positions
  localparam int SPD_REV_LSB       = 4;
  localparam int SPD_A_INTER_BYTE_DELAY_EN       = 7;
  localparam int SPD_A_PARITY_OFF  = 5;
  localparam int SPD_A_TIMEOUT_OFF = 4;
  localparam int SPD_A_RSP_OFF     = 3;
  localparam int SPD_B_NACK_OFF    = 4;
  localparam int SPD_B_CONT_OFF    = 3;
  localparam int SPD_B_DISABLE     = 2;
  localparam int SPD_K_USER_ROW    = 5;
  localparam int SPD_K_NVM_PROG    = 4;
  localparam int SPD_K_ERASE       = 3;
  localparam int SPD_SC_URFINAL    = 1;
  localparam int SPD_SC_CLKREQ     = 0;
  localparam int SPD_SS_NVM_PROG_KEY_ACTIVE    = 3;
  // Writable masks and reset values
  localparam logic [7:0] SPD_CTRL_A_MASK  = 8'hbf;
  localparam logic [7:0] SPD_CTRL_B_MASK  = 8'h1c;
  localparam logic [7:0] SPD_CLK_SEL_MASK = 8'h03;
  localparam logic [7:0] SPD_CLK_SEL_RST  = 8'h03;
  localparam logic [7:0] SPD_SYS_CTRL_RST = 8'h01;
  localparam logic [7:0] SPD_ZERO8        = 8'h00;
  // Error signature codes
  localparam logic [2:0] SPD_ERR_NONE     = 3'h0;
  localparam logic [2:0] SPD_ERR_PARITY   = 3'h1;
  localparam logic [2:0] SPD_ERR_FRAME    = 3'h2;
  localparam logic [2:0] SPD_ERR_TIMEOUT  = 3'h3;
  localparam logic [2:0] SPD_ERR_CLOCKREC = 3'h4;
  localparam logic [2:0] SPD_ERR_BUS      = 3'h6;
  localparam logic [2:0] SPD_ERR_CONTEND  = 3'h7;
  // Guard time, inter-byte gap, reset request code, time-out
  localparam logic [2:0] SPD_GT_RESERVED  = 3'h7;
  localparam logic [7:0] SPD_GT_MAX       = 8'h80;
  localparam logic [1:0] SPD_IBD_BITS     = 2'h2;
  localparam logic [7:0] SPD_RST_CODE     = 8'h59;
  localparam int         SPD_TIMEOUT_CYC  = 65536;
  localparam int         SPD_KEY_BITS     = 64;
  // Key signatures, shifted in least significant bit first
  localparam logic [63:0] SPD_KEY_ERASE = 64'h4e564d4572617365;
  localparam logic [63:0] SPD_KEY_NVM   = 64'h4e564d50726f6720;
  localparam logic [63:0] SPD_KEY_UROW  = 64'h4e564d5573267465;
endpackage

// >>> logic/spd_regs.sv
// Configuration, error signature and key status registers of the debug port
`timescale 1ns/1ps
module spd_regs #(
  parameter int         TIMEOUT_CYCLES = spd_pkg::SPD_TIMEOUT_CYC,
  parameter logic [3:0] IMPL_REV       = 4'h1  // Arbitrary value
) (
  input  logic       sys_clk,
  input  logic       nrst,
  input  logic       reg_wr,
  input  logic       reg_rd,
  input  logic [3:0] reg_addr,
  input  logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic       reg_rvalid,
  input  logic       err_parity,
  input  logic       err_frame,
  input  logic       err_clock_rec,
  input  logic       err_bus,
  input  logic       err_contention,
  input  logic       acc_wait,
  input  logic       key_bit_valid,
  input  logic       key_bit,
  input  logic       key_end,
  input  logic [7:0] sys_status,
  input  logic [7:0] crc_status,
  output logic       timeout_pulse,
  output logic [1:0] inter_byte_gap,
  output logic       parity_check_en,
  output logic       response_sig_en,
  output logic [7:0] guard_cycles,
  output logic       nack_en,
  output logic       contention_detect_en,
  output logic       port_reset_pulse,
  output logic       clk_req,
  output logic [1:0] clk_sel,
  output logic       user_row_final,
  output logic       sys_reset_req,
  output logic       user_row_key_active,
  output logic       nvm_prog_key_active,
  output logic       erase_key_active
);
  import spd_pkg::*;

  localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);

  // Guard length: each code halves the time; the reserved code falls back to 128
  function automatic logic [7:0] guard_len(input logic [2:0] sel);
    if (sel == SPD_GT_RESERVED) begin
      return SPD_GT_MAX;
    end
    return SPD_GT_MAX >> sel;
  endfunction

  // Highest priority first, so a contention never hides behind a parity slip
  function automatic logic [2:0] err_code(input logic [5:0] ev);
    if (ev[5]) return SPD_ERR_CONTEND;
    if (ev[4]) return SPD_ERR_BUS;
    if (ev[3]) return SPD_ERR_CLOCKREC;
    if (ev[2]) return SPD_ERR_TIMEOUT;
    if (ev[1]) return SPD_ERR_FRAME;
    return SPD_ERR_PARITY;
  endfunction

  logic [7:0]      ctrl_a_q, ctrl_a_d;
  logic [7:0]      ctrl_b_q, ctrl_b_d;
  logic [7:0]      clk_sel_q, clk_sel_d;
  logic [7:0]      sys_ctrl_q, sys_ctrl_d;
  logic [2:0]      sig_q, sig_d;
  logic            rst_req_q, rst_req_d;
  logic            urfin_q, urfin_d;
  logic            pdis_q, pdis_d;
  logic [2:0]      keys_q, keys_d;  // {user row, nvm, erase}
  logic [63:0]     shift_q, shift_d;
  logic [TO_W-1:0] to_cnt_q, to_cnt_d;
  logic            to_evt;
  logic [7:0]      rdata_q, rdata_d;
  logic            rvalid_q;
  logic [5:0]      err_ev;
  logic            wr_ctrl_b, wr_rst, disable_now;

  // Write strobes decoded once; the debugger port is the only way in
  assign wr_ctrl_b   = reg_wr && (reg_addr == SPD_OFS_CTRL_B);
  assign wr_rst      = reg_wr && (reg_addr == SPD_OFS_RESET_REQ);
  assign disable_now = wr_ctrl_b && reg_wdata[SPD_B_DISABLE];

  // Time-out watch on the access layer answer
  always_comb begin
    to_cnt_d = to_cnt_q;
    to_evt   = 1'b0;
    if (!acc_wait || ctrl_a_q[SPD_A_TIMEOUT_OFF]) begin
      to_cnt_d = '0;
    end else if (to_cnt_q == TO_LAST) begin
      to_evt   = 1'b1;
      to_cnt_d = '0;
    end else begin
      to_cnt_d = to_cnt_q + 1'b1;
    end
  end

  // Error events after their enables
  assign err_ev = {err_contention && !ctrl_b_q[SPD_B_CONT_OFF],
                   err_bus, err_clock_rec, to_evt, err_frame,
                   err_parity && !ctrl_a_q[SPD_A_PARITY_OFF]};

  // Configuration, signature, reset request and key next state
  always_comb begin
    ctrl_a_d   = ctrl_a_q;
    ctrl_b_d   = ctrl_b_q;
    clk_sel_d  = clk_sel_q;
    sys_ctrl_d = sys_ctrl_q;
    sig_d      = sig_q;
    rst_req_d  = rst_req_q;
    urfin_d    = 1'b0;
    pdis_d     = 1'b0;
    keys_d     = keys_q;
    shift_d    = shift_q;
    if (reg_rd && (reg_addr == SPD_OFS_ERRSIG)) begin
      sig_d = SPD_ERR_NONE;
    end
    // New error after the read clear, so an error in the read cycle survives
    if (|err_ev) begin
      sig_d = err_code(err_ev);
    end
    if (reg_wr) begin
      unique case (reg_addr)
        SPD_OFS_CTRL_A:     ctrl_a_d = reg_wdata & SPD_CTRL_A_MASK;
        SPD_OFS_CTRL_B:     ctrl_b_d = reg_wdata & SPD_CTRL_B_MASK;
        SPD_OFS_CLK_SEL:    clk_sel_d = reg_wdata & SPD_CLK_SEL_MASK;
        SPD_OFS_SYS_CTRL_A: begin
          sys_ctrl_d[SPD_SC_CLKREQ] = reg_wdata[SPD_SC_CLKREQ];
          urfin_d = reg_wdata[SPD_SC_URFINAL] && keys_q[2];
        end
        SPD_OFS_KEY_STATUS: begin
          // Debugger closes the user-row session by writing a one
          if (reg_wdata[SPD_K_USER_ROW]) begin
            keys_d[2] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (wr_rst) begin
      rst_req_d = (reg_wdata == SPD_RST_CODE);
      if (reg_wdata == SPD_RST_CODE) begin
        keys_d[0] = 1'b0;
      end
    end
    if (keys_q[1] && sys_status[SPD_SS_NVM_PROG_KEY_ACTIVE]) begin
      keys_d[1] = 1'b0;
    end
    // Key signature, oldest bit ends in the LSB after 64 shifts
    if (key_bit_valid) begin
      shift_d = {key_bit, shift_q[SPD_KEY_BITS-1:1]};
    end
    if (key_end) begin
      if (shift_q == SPD_KEY_UROW) keys_d[2] = 1'b1;
      if (shift_q == SPD_KEY_NVM) keys_d[1] = 1'b1;
      if (shift_q == SPD_KEY_ERASE) keys_d[0] = 1'b1;
    end
    // Port disable wipes all physical settings and every key
    if (disable_now) begin
      ctrl_a_d   = SPD_ZERO8;
      ctrl_b_d   = SPD_ZERO8;
      clk_sel_d  = SPD_CLK_SEL_RST;
      sys_ctrl_d = SPD_ZERO8;
      sig_d      = SPD_ERR_NONE;
      rst_req_d  = 1'b0;
      keys_d     = '0;
      shift_d    = '0;
      pdis_d     = 1'b1;
    end
  end

  // Read mux; unmapped and reserved offsets answer zero
  always_comb begin
    rdata_d = SPD_ZERO8;
    unique case (reg_addr)
      SPD_OFS_REVISION:   rdata_d = {IMPL_REV, 4'h0};
      SPD_OFS_ERRSIG:     rdata_d = {5'h00, sig_q};
      SPD_OFS_CTRL_A:     rdata_d = ctrl_a_q;
      SPD_OFS_CTRL_B:     rdata_d = ctrl_b_q;
      SPD_OFS_KEY_STATUS: rdata_d = {2'h0, keys_q, 3'h0};
      SPD_OFS_RESET_REQ:  rdata_d = {7'h00, rst_req_q};
      SPD_OFS_CLK_SEL:    rdata_d = clk_sel_q;
      SPD_OFS_SYS_CTRL_A: rdata_d = sys_ctrl_q;
      SPD_OFS_SYS_STATUS: rdata_d = sys_status;
      SPD_OFS_CRC_STATUS: rdata_d = crc_status;
      default:            rdata_d = SPD_ZERO8;
    endcase
    if (!reg_rd) begin
      rdata_d = rdata_q;
    end
  end

  // All state registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_a_q   <= SPD_ZERO8;
      ctrl_b_q   <= SPD_ZERO8;
      clk_sel_q  <= SPD_CLK_SEL_RST;
      sys_ctrl_q <= SPD_SYS_CTRL_RST;
      sig_q      <= SPD_ERR_NONE;
      rst_req_q  <= 1'b0;
      urfin_q    <= 1'b0;
      pdis_q     <= 1'b0;
      keys_q     <= '0;
      shift_q    <= '0;
      to_cnt_q   <= '0;
      rdata_q    <= SPD_ZERO8;
      rvalid_q   <= 1'b0;
    end else begin
      ctrl_a_q   <= ctrl_a_d;
      ctrl_b_q   <= ctrl_b_d;
      clk_sel_q  <= clk_sel_d;
      sys_ctrl_q <= sys_ctrl_d;
      sig_q      <= sig_d;
      rst_req_q  <= rst_req_d;
      urfin_q    <= urfin_d;
      pdis_q     <= pdis_d;
      keys_q     <= keys_d;
      shift_q    <= shift_d;
      to_cnt_q   <= to_cnt_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= reg_rd;
    end
  end

  // Outputs from registers, except timeout_pulse, which follows acc_wait in the same cycle
  assign reg_rdata            = rdata_q;
  assign reg_rvalid           = rvalid_q;
  assign timeout_pulse        = to_evt;
  assign inter_byte_gap       = ctrl_a_q[SPD_A_INTER_BYTE_DELAY_EN] ? SPD_IBD_BITS : 2'h0;
  assign parity_check_en      = !ctrl_a_q[SPD_A_PARITY_OFF];
  assign response_sig_en      = !ctrl_a_q[SPD_A_RSP_OFF];
  assign guard_cycles         = guard_len(ctrl_a_q[2:0]);
  assign nack_en              = !ctrl_b_q[SPD_B_NACK_OFF] && response_sig_en;
  assign contention_detect_en = !ctrl_b_q[SPD_B_CONT_OFF];
  assign port_reset_pulse     = pdis_q;
  assign clk_req              = sys_ctrl_q[SPD_SC_CLKREQ];
  assign clk_sel              = clk_sel_q[1:0];
  assign user_row_final       = urfin_q;
  assign sys_reset_req        = rst_req_q;
  assign user_row_key_active  = keys_q[2];
  assign nvm_prog_key_active  = keys_q[1];
  assign erase_key_active     = keys_q[0];

  // Checks on the block's own behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_reset_code;
    reg_wr && reg_addr == SPD_OFS_RESET_REQ && reg_wdata == SPD_RST_CODE && !disable_now;
  endsequence
  sequence s_erase_armed;
    keys_q[0] && !key_end;
  endsequence

  rev_read_a: assert property (reg_rd && reg_addr == SPD_OFS_REVISION |=>
    reg_rvalid && reg_rdata == {IMPL_REV, 4'h0}) else $error("revision read wrong");
  sig_clear_a: assert property (reg_rd && reg_addr == SPD_OFS_ERRSIG && !(|err_ev)
    && !disable_now |=> sig_q == SPD_ERR_NONE) else $error("signature not cleared");
  contend_code_a: assert property (err_contention && contention_detect_en
    && !disable_now |=> sig_q == SPD_ERR_CONTEND) else $error("contention code wrong");
  parity_code_a: assert property (err_parity && parity_check_en && !(|err_ev[5:1])
    && !disable_now |=> sig_q == SPD_ERR_PARITY) else $error("parity code wrong");
  parity_off_a: assert property (sig_q == SPD_ERR_NONE && !parity_check_en
    && err_parity && !(|err_ev[5:1]) |=> sig_q == SPD_ERR_NONE) else $error("parity not ignored");
  timeout_code_a: assert property (to_evt && !(|err_ev[5:3]) && !disable_now |=>
    sig_q == SPD_ERR_TIMEOUT) else $error("time-out code wrong");
  sig_hold_a: assert property (!(|err_ev) && !reg_rd && !disable_now |=>
    $stable(sig_q)) else $error("signature changed without cause");
  rst_req_a: assert property (s_reset_code |=> sys_reset_req ##1
    (sys_reset_req || $past(wr_rst) || $past(disable_now))) else $error("reset request lost");
  rst_rel_a: assert property (wr_rst && reg_wdata != SPD_RST_CODE |=>
    !sys_reset_req) else $error("reset not released");
  erase_clr_a: assert property (s_erase_armed ##0 s_reset_code |=>
    !erase_key_active) else $error("erase key not cleared");
  key_match_a: assert property (key_end && shift_q == SPD_KEY_ERASE && !disable_now |=>
    erase_key_active) else $error("erase key not set");
  disable_a: assert property (disable_now |=> ctrl_a_q == SPD_ZERO8 && keys_q == '0
    && !clk_req && port_reset_pulse) else $error("port disable incomplete");
  guard_a: assert property (reg_wr && reg_addr == SPD_OFS_CTRL_A && reg_wdata[2:0] == 3'h6
    |=> guard_cycles == 8'h02) else $error("guard time wrong");
endmodule

// >>> verification/single_pin_debug_config_regs_test.sv
// Self-checking bench for the debug port register set
`timescale 1ns/1ps
module single_pin_debug_config_regs_test;
  import spd_pkg::*;
  localparam int         TMO = 16;   // Short time-out keeps the run brief
  localparam logic [3:0] REV = 4'h5; // Arbitrary value
  logic        sys_clk, nrst, reg_wr, reg_rd, acc_wait, start, slow, seen;
  logic        reg_rvalid, timeout_pulse, parity_check_en, response_sig_en;
  logic        nack_en, contention_detect_en, port_reset_pulse, clk_req;
  logic        user_row_final, sys_reset_req, uk, nk, ek, kv, kb, ke, done;
  logic [1:0]  inter_byte_gap, clk_sel;
  logic [3:0]  reg_addr;
  logic [4:0]  err, ev;
  logic [7:0]  reg_wdata, sys_status, crc_status, reg_rdata, guard_cycles, va, vb;
  logic [63:0] key;
  int          fail_count, tests_run, cyc, n;
  spd_regs #(.TIMEOUT_CYCLES(TMO), .IMPL_REV(REV)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .err_parity(err[0]), .err_frame(err[1]),
    .err_clock_rec(err[2]), .err_bus(err[3]), .err_contention(err[4]),
    .acc_wait(acc_wait), .key_bit_valid(kv), .key_bit(kb), .key_end(ke),
    .sys_status(sys_status), .crc_status(crc_status), .timeout_pulse(timeout_pulse),
    .inter_byte_gap(inter_byte_gap), .parity_check_en(parity_check_en),
    .response_sig_en(response_sig_en), .guard_cycles(guard_cycles), .nack_en(nack_en),
    .contention_detect_en(contention_detect_en), .port_reset_pulse(port_reset_pulse),
    .clk_req(clk_req), .clk_sel(clk_sel), .user_row_final(user_row_final),
    .sys_reset_req(sys_reset_req), .user_row_key_active(uk),
    .nvm_prog_key_active(nk), .erase_key_active(ek));
  spd_dbg_model i_dbg (.sys_clk(sys_clk), .start(start), .slow(slow), .key(key),
    .key_bit_valid(kv), .key_bit(kb), .key_end(ke), .done(done));
  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus cycles: strobe for one cycle, answer sampled a cycle later
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk("rvalid", {7'h0, reg_rvalid}, 8'h01);
    chk($sformatf("reg %h", a), reg_rdata, exp);
  endtask
  task automatic errp(input logic [4:0] e);
    @(negedge sys_clk);
    err = e;
    @(negedge sys_clk);
    err = 5'h0;
  endtask
  task automatic key_in(input logic [63:0] k);
    key  = k;
    slow = 1'($urandom);
    @(negedge sys_clk);
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge sys_clk);
    chk("key done", {7'h0, done}, 8'h01);
  endtask
  function automatic logic [7:0] gexp(input logic [2:0] c);
    return (c == 3'h7) ? SPD_GT_MAX : (SPD_GT_MAX >> c);
  endfunction
  // Highest-priority code among the raised error lines
  function automatic logic [7:0] eexp(input logic [4:0] e, input logic pd, input logic cd);
    if (e[4] && !cd) return 8'h07;
    if (e[3]) return 8'h06;
    if (e[2]) return 8'h04;
    if (e[1]) return 8'h02;
    if (e[0] && !pd) return 8'h01;
    return 8'h00;
  endfunction
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    {nrst, reg_wr, reg_rd, acc_wait, start, slow, err, key} = '0;
    {reg_addr, reg_wdata} = '0;
    void'($urandom(32'he3e0));
    sys_status = 8'($urandom) & 8'hf7;
    crc_status = 8'($urandom);
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    // Reset values, read-only places and unmapped offsets
    chk("guard", guard_cycles, SPD_GT_MAX);
    chk("clkreq", {7'h0, clk_req}, 8'h01);
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), a == 0 ? {REV, 4'h0} : a == 9 ? 8'h03 : a == 10 ? 8'h01 :
         a == 11 ? sys_status : a == 12 ? crc_status : 8'h00);
      wr(4'(a < 2 ? a : 5), 8'hff);
    end
    rd(0, {REV, 4'h0});
    rd(1, 8'h00);
    // Every guard code with random control fields beside it
    for (int c = 0; c < 8; c++) begin
      va = 8'($urandom) & 8'hf8 | 8'(c);
      vb = 8'($urandom) & 8'h18;
      wr(2, va);
      wr(3, vb);
      rd(2, va & SPD_CTRL_A_MASK);
      rd(3, vb);
      chk("gap", {6'h0, inter_byte_gap}, va[7] ? 8'h02 : 8'h00);
      chk("parity", {7'h0, parity_check_en}, {7'h0, ~va[5]});
      chk("rsp", {7'h0, response_sig_en}, {7'h0, ~va[3]});
      chk("guard", guard_cycles, gexp(3'(c)));
      chk("cont", {7'h0, contention_detect_en}, {7'h0, ~vb[3]});
      chk("nack", {7'h0, nack_en}, {7'h0, ~vb[4] & ~va[3]});
    end
    // Each error alone, then random mixes with masking bits
    for (int i = 0; i < 20; i++) begin
      va = (i < 5) ? 8'h00 : 8'($urandom) & 8'h20;
      vb = (i < 5) ? 8'h00 : 8'($urandom) & 8'h08;
      ev = (i < 5) ? 5'(5'h1 << i) : 5'($urandom);
      wr(2, va);
      wr(3, vb);
      errp(ev);
      rd(1, eexp(ev, va[5], vb[3]));
    end
    // Both masks on: a masked parity and contention leave the field at zero
    wr(2, 8'h20);
    wr(3, 8'h08);
    errp(5'h11);
    rd(1, 8'h00);
    // Code held across unrelated traffic, then cleared by its read
    wr(2, 8'h00);
    wr(3, 8'h00);
    errp(5'h08);
    wr(2, 8'h00);
    rd(1, 8'h06);
    rd(1, 8'h00);
    // Access layer silent: the time-out fires on the last waiting cycle
    acc_wait = 1'b1;
    repeat (TMO - 2) @(negedge sys_clk);
    chk("tmo early", {7'h0, timeout_pulse}, 8'h00);
    @(negedge sys_clk);
    chk("tmo", {7'h0, timeout_pulse}, 8'h01);
    @(negedge sys_clk);
    acc_wait = 1'b0;
    rd(1, 8'h03);
    // Detection off: a long wait raises nothing
    wr(2, 8'h10);
    acc_wait = 1'b1;
    repeat (2 * TMO) begin
      @(negedge sys_clk);
      chk("tmo off", {7'h0, timeout_pulse}, 8'h00);
    end
    acc_wait = 1'b0;
    rd(1, 8'h00);
    wr(2, 8'h00);
    // Erase key, consumed by the reset request
    key_in(SPD_KEY_ERASE);
    rd(7, 8'h08);
    wr(8, SPD_RST_CODE);
    chk("sysrst", {7'h0, sys_reset_req}, 8'h01);
    rd(7, 8'h00);
    rd(8, 8'h01);
    wr(8, 8'($urandom) & 8'hfe);
    chk("sysrst off", {7'h0, sys_reset_req}, 8'h00);
    // Programming key drops once programming has started
    key_in(SPD_KEY_NVM);
    rd(7, 8'h10);
    sys_status[SPD_SS_NVM_PROG_KEY_ACTIVE] = 1'b1;
    @(negedge sys_clk);
    sys_status[SPD_SS_NVM_PROG_KEY_ACTIVE] = 1'b0;
    chk("nvm key", {7'h0, nk}, 8'h00);
    // User-row session, final write pulses user_row_final, then a key status write closes it
    key_in(SPD_KEY_UROW);
    rd(7, 8'h20);
    wr(4'ha, 8'h02);
    chk("urfinal", {7'h0, user_row_final}, 8'h01);
    chk("clkreq low", {7'h0, clk_req}, 8'h00);
    wr(7, 8'h20);
    rd(7, 8'h00);
    key_in({$urandom, $urandom});
    rd(7, 8'h00);
    // Port disable wipes configuration, clock settings and keys
    key_in(SPD_KEY_ERASE);
    wr(4'h9, 8'h00);
    chk("clksel", {6'h0, clk_sel}, 8'h00);
    wr(2, 8'hbf);
    wr(4'ha, 8'h01);
    chk("clkreq high", {7'h0, clk_req}, 8'h01);
    wr(3, 8'h1c);
    chk("portrst", {7'h0, port_reset_pulse}, 8'h01);
    chk("clkreq off", {7'h0, clk_req}, 8'h00);
    chk("clksel rst", {6'h0, clk_sel}, 8'h03);
    chk("erase off", {7'h0, ek}, 8'h00);
    rd(2, 8'h00);
    rd(3, 8'h00);
    report_and_stop();
  end
endmodule

// >>> verification/spd_dbg_model.sv
// Debugger-side model that shifts key signatures into the port
`timescale 1ns/1ps
module spd_dbg_model (
  input  wire logic        sys_clk,
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic [63:0] key,
  output logic             key_bit_valid,
  output logic             key_bit,
  output logic             key_end,
  output logic             done
);
  initial begin
    key_bit_valid = 1'b0;
    key_bit       = 1'b0;
    key_end       = 1'b0;
    done          = 1'b0;
  end
  // One key instruction per start; never touches signature-disable
  always @(posedge start) begin
    done = 1'b0;
    for (int i = 0; i < 64; i++) begin
      @(negedge sys_clk);
      key_bit_valid = 1'b1;
      key_bit       = key[i];
      @(negedge sys_clk);
      key_bit_valid = 1'b0;
      key_bit       = ~key[i]; // Idle line shows no stale bit
      if (slow) repeat (2) @(negedge sys_clk);
    end
    key_end = 1'b1;
    @(negedge sys_clk);
    key_end = 1'b0;
    done    = 1'b1;
  end
endmodule
